// ### hw/msr_bank.sv
// Model-specific register bank of one processor core
`timescale 1ns/100ps
// Function
// R1: Cycle counter resets zero, counts, read-write
// R2: Counter rate independent of power states
// R3: Base address field bits 47:12 read-write
// R4: Base register resets to FEE00000, bit8 boot
// R5: Enable set: registers reachable, all interrupts
// R6: Enable clear: only non-vectored interrupts accepted
// R7: Bit 8 read-write boot core flag
// R8: Cluster register writes fault, error zero
// R9: Cluster field read-only, reads 00b
// R10: Capabilities read-only, reset 0508h, write-combining
// R11: Capability bit 8 reports fixed ranges
// R12: Capability bits 7:0 give variable count
// R13: Code segment 15:0 read-write, upper zero
// R14: Software writes zeros to must-be-zero fields
// R15: Stack pointer 31:0 read-write, reset zero
// R16: Index 0 forwards to address 040E
// R17: Index 1 forwards to address 040D
// R18: Access only by register instructions, indexed
module msr_bank (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Straps
  input  wire logic        boot_core_i,
  // Register instruction request
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic [63:0] req_wdata_i,
  output logic             req_ready_o,
  // Register instruction answer
  output logic             rsp_valid_o,
  output logic      [63:0] rsp_rdata_o,
  output logic             rsp_gp_fault_o,
  output logic      [15:0] rsp_err_code_o,
  // Machine-check register port
  output logic             mca_req_valid_o,
  output logic             mca_req_write_o,
  output logic      [31:0] mca_req_addr_o,
  output logic      [63:0] mca_req_wdata_o,
  input  wire logic        mca_rsp_valid_i,
  input  wire logic [63:0] mca_rsp_rdata_i,
  // Interrupt controller controls
  output logic      [63:0] irq_ctrl_base_o,
  output logic             irq_ctrl_reg_set_en_o,
  output logic             irq_accept_vectored_o,
  // Other state
  output logic      [63:0] cycle_counter_o,
  output logic      [15:0] syscall_code_segment_o,
  output logic      [31:0] syscall_stack_pointer_o
);

  ////////////////////////////////////////////////////////////////////////////////
  logic                   rst_n;
  logic                   boot_captured_r;
  logic [63:0]            irq_ctrl_base_r;
  logic [63:0]            syscall_cs_r;
  logic [63:0]            syscall_sp_r;
  logic [63:0]            count;
  msr_pkg::access_state_e state_r;
  logic                   take;
  logic                   is_alias;
  logic                   wr_counter;
  logic [63:0]            rdata_nxt;
  logic                   fault_nxt;

  rst_sync u_rst_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .rstn_o  (rst_n)
  );

  // R18: one request at a time, by index
  assign take       = req_valid_i && req_ready_o;
  assign is_alias   = (req_addr_i == msr_pkg::ADDR_LSU_MCA_ADDRESS_ALIAS) ||
                      (req_addr_i == msr_pkg::ADDR_LSU_MCA_STATUS_ALIAS);
  assign wr_counter = take && req_write_i && (req_addr_i == msr_pkg::ADDR_CYCLE_COUNTER);

  // R1: counter with software load
  cycle_counter_unit u_counter (
    .clock_i      (clock_i),
    .rstn_i       (rst_n),
    .load_i       (wr_counter),
    .load_value_i (req_wdata_i),
    .count_o      (count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Strap caught one cycle after release; requests held off until then
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      boot_captured_r <= 1'b0;
    else
      boot_captured_r <= 1'b1;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_ctrl_base_r <= msr_pkg::IRQ_CTRL_BASE_RESET;
    // R4: bit 8 loaded from the boot strap
    else if (!boot_captured_r)
      irq_ctrl_base_r[msr_pkg::BOOT_CORE_BIT] <= boot_core_i;
    // R3: base field, enable and boot flag writable
    // R7: boot flag rewritable by software
    else if (take && req_write_i && (req_addr_i == msr_pkg::ADDR_IRQ_CTRL_BASE))
      irq_ctrl_base_r <= req_wdata_i & msr_pkg::IRQ_CTRL_BASE_WMASK;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      syscall_cs_r <= msr_pkg::SYSCALL_CS_RESET;
    // R13: only the selector is stored
    else if (take && req_write_i && (req_addr_i == msr_pkg::ADDR_SYSCALL_CODE_SEGMENT))
      syscall_cs_r <= req_wdata_i & msr_pkg::SYSCALL_CS_WMASK;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      syscall_sp_r <= msr_pkg::SYSCALL_SP_RESET;
    // R15: low word stored
    else if (take && req_write_i && (req_addr_i == msr_pkg::ADDR_SYSCALL_STACK_POINTER))
      syscall_sp_r <= req_wdata_i & msr_pkg::SYSCALL_SP_WMASK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Local read data and fault decision
  always_comb
  begin
    rdata_nxt = 64'h0000_0000_0000_0000;
    fault_nxt = 1'b0;
    case (req_addr_i)
      msr_pkg::ADDR_CYCLE_COUNTER:         rdata_nxt = count;
      msr_pkg::ADDR_IRQ_CTRL_BASE:         rdata_nxt = irq_ctrl_base_r;
      // R8: any write refused with a fault
      // R9: cluster field always reads zero
      msr_pkg::ADDR_CLUSTER_IDENT:
      begin
        rdata_nxt = msr_pkg::CLUSTER_IDENT_RESET;
        fault_nxt = req_write_i;
      end
      // R10: capability word is a constant
      // R11: bit 8 fixed ranges present
      // R12: low byte counts variable pairs
      msr_pkg::ADDR_MEMTYPE_RANGE_CAPS:    rdata_nxt = msr_pkg::MEMTYPE_RANGE_CAPS_RESET;
      msr_pkg::ADDR_SYSCALL_CODE_SEGMENT:  rdata_nxt = syscall_cs_r;
      msr_pkg::ADDR_SYSCALL_STACK_POINTER: rdata_nxt = syscall_sp_r;
      // Unknown index faults, as an unimplemented register would
      default:                             fault_nxt = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencing; aliases wait on the machine-check port
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r         <= msr_pkg::ST_IDLE;
      req_ready_o     <= 1'b0;
      rsp_valid_o     <= 1'b0;
      rsp_rdata_o     <= 64'h0000_0000_0000_0000;
      rsp_gp_fault_o  <= 1'b0;
      rsp_err_code_o  <= 16'h0000;
      mca_req_valid_o <= 1'b0;
      mca_req_write_o <= 1'b0;
      mca_req_addr_o  <= 32'h0000_0000;
      mca_req_wdata_o <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      rsp_valid_o     <= 1'b0;
      mca_req_valid_o <= 1'b0;
      case (state_r)
        msr_pkg::ST_IDLE:
        begin
          req_ready_o <= boot_captured_r;
          if (take && is_alias)
          begin
            // R16: index 0 redirected
            // R17: index 1 redirected
            state_r         <= msr_pkg::ST_ALIAS_WAIT;
            req_ready_o     <= 1'b0;
            mca_req_valid_o <= 1'b1;
            mca_req_write_o <= req_write_i;
            mca_req_addr_o  <= (req_addr_i == msr_pkg::ADDR_LSU_MCA_ADDRESS_ALIAS) ?
                               msr_pkg::ADDR_LSU_MCA_ADDRESS : msr_pkg::ADDR_LSU_MCA_STATUS;
            mca_req_wdata_o <= req_wdata_i;
          end
          else if (take)
          begin
            rsp_valid_o    <= 1'b1;
            rsp_rdata_o    <= (req_write_i || fault_nxt) ? 64'h0000_0000_0000_0000 : rdata_nxt;
            rsp_gp_fault_o <= fault_nxt;
            rsp_err_code_o <= msr_pkg::GP_ERROR_CODE;
          end
        end
        msr_pkg::ST_ALIAS_WAIT:
        begin
          if (mca_rsp_valid_i && !mca_req_valid_o)
          begin
            state_r        <= msr_pkg::ST_IDLE;
            req_ready_o    <= 1'b1;
            rsp_valid_o    <= 1'b1;
            rsp_rdata_o    <= mca_req_write_o ? 64'h0000_0000_0000_0000 : mca_rsp_rdata_i;
            rsp_gp_fault_o <= 1'b0;
          end
        end
        default: state_r <= msr_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered views of state; all outputs come from flops
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_ctrl_base_o         <= msr_pkg::IRQ_CTRL_BASE_RESET;
      irq_ctrl_reg_set_en_o   <= 1'b0;
      irq_accept_vectored_o   <= 1'b0;
      cycle_counter_o         <= msr_pkg::CYCLE_COUNTER_RESET;
      syscall_code_segment_o  <= 16'h0000;
      syscall_stack_pointer_o <= 32'h0000_0000;
    end
    else
    begin
      irq_ctrl_base_o         <= irq_ctrl_base_r;
      // R5: enable opens register set and vectored interrupts
      // R6: disabled leaves only non-vectored ones
      irq_ctrl_reg_set_en_o   <= irq_ctrl_base_r[msr_pkg::IRQ_ENABLE_BIT];
      irq_accept_vectored_o   <= irq_ctrl_base_r[msr_pkg::IRQ_ENABLE_BIT];
      // R2: no power-state term anywhere on this path
      cycle_counter_o         <= count;
      syscall_code_segment_o  <= syscall_cs_r[15:0];
      syscall_stack_pointer_o <= syscall_sp_r[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sampled rst_n skips the release edge, where the counter still holds
  a_counter_advances: assert property ( // R1
    @(posedge clock_i) disable iff (!rst_n)
    rst_n && !wr_counter |=> count == $past(count) + 64'h0000_0000_0000_0001)
    else $error("cycle counter did not advance by one");

  a_counter_steady_rate: assert property ( // R2
    @(posedge clock_i) disable iff (!rst_n)
    rst_n && !wr_counter ##1 !wr_counter
    |=> count == $past(count, 2) + 64'h0000_0000_0000_0002)
    else $error("cycle counter rate not constant");

  a_base_field_write: assert property ( // R3
    @(posedge clock_i) disable iff (!rst_n)
    take && req_write_i && req_addr_i == msr_pkg::ADDR_IRQ_CTRL_BASE
    |=> irq_ctrl_base_r[47:12] == $past(req_wdata_i[47:12]))
    else $error("base address field not stored");

  a_base_mbz_zero: assert property ( // R4
    @(posedge clock_i) disable iff (!rst_n)
    irq_ctrl_base_r[10:9] == 2'h0 && irq_ctrl_base_r[7:0] == 8'h00
    && irq_ctrl_base_r[63:48] == 16'h0000)
    else $error("must-be-zero base bits set");

  a_enable_follows: assert property ( // R5
    @(posedge clock_i) disable iff (!rst_n)
    irq_ctrl_base_r[11] |=> irq_ctrl_reg_set_en_o && irq_accept_vectored_o)
    else $error("enable not reflected");

  a_disable_follows: assert property ( // R6
    @(posedge clock_i) disable iff (!rst_n)
    !irq_ctrl_base_r[11] |=> !irq_ctrl_reg_set_en_o && !irq_accept_vectored_o)
    else $error("disable not reflected");

  a_boot_strap: assert property ( // R7
    @(posedge clock_i) disable iff (!rst_n)
    rst_n && !boot_captured_r |=> irq_ctrl_base_r[8] == $past(boot_core_i))
    else $error("boot core flag not captured");

  a_cluster_fault: assert property ( // R8
    @(posedge clock_i) disable iff (!rst_n)
    take && req_write_i && req_addr_i == msr_pkg::ADDR_CLUSTER_IDENT
    |=> rsp_valid_o && rsp_gp_fault_o && rsp_err_code_o == 16'h0000)
    else $error("cluster write not faulted");

  a_caps_read: assert property ( // R10
    @(posedge clock_i) disable iff (!rst_n)
    take && !req_write_i && req_addr_i == msr_pkg::ADDR_MEMTYPE_RANGE_CAPS
    |=> rsp_rdata_o == 64'h0000_0000_0000_0508 && !rsp_gp_fault_o)
    else $error("capability word wrong");

  a_cs_upper_zero: assert property ( // R13
    @(posedge clock_i) disable iff (!rst_n)
    syscall_cs_r[63:16] == 48'h0000_0000_0000)
    else $error("code segment upper bits set");

  a_sp_upper_zero: assert property ( // R15
    @(posedge clock_i) disable iff (!rst_n)
    syscall_sp_r[63:32] == 32'h0000_0000)
    else $error("stack pointer upper bits set");

  a_alias_address: assert property ( // R16
    @(posedge clock_i) disable iff (!rst_n)
    take && req_addr_i == 32'h0000_0000
    |=> mca_req_valid_o && mca_req_addr_o == 32'h0000_040E)
    else $error("index 0 not forwarded");

  a_alias_status: assert property ( // R17
    @(posedge clock_i) disable iff (!rst_n)
    take && req_addr_i == 32'h0000_0001
    |=> mca_req_valid_o && mca_req_addr_o == 32'h0000_040D ##1 !req_ready_o)
    else $error("index 1 not forwarded");

endmodule : msr_bank

// ### hw/msr_pkg.sv
// Constants for the core model-specific register bank
package msr_pkg;

  // Register indices
  localparam logic [31:0] ADDR_LSU_MCA_ADDRESS_ALIAS = 32'h0000_0000;
  localparam logic [31:0] ADDR_LSU_MCA_STATUS_ALIAS  = 32'h0000_0001;
  localparam logic [31:0] ADDR_CYCLE_COUNTER         = 32'h0000_0010;
  localparam logic [31:0] ADDR_IRQ_CTRL_BASE         = 32'h0000_001B;
  localparam logic [31:0] ADDR_CLUSTER_IDENT         = 32'h0000_002A;
  localparam logic [31:0] ADDR_MEMTYPE_RANGE_CAPS    = 32'h0000_00FE;
  localparam logic [31:0] ADDR_SYSCALL_CODE_SEGMENT  = 32'h0000_0174;
  localparam logic [31:0] ADDR_SYSCALL_STACK_POINTER = 32'h0000_0175;

  // Alias targets
  localparam logic [31:0] ADDR_LSU_MCA_ADDRESS       = 32'h0000_040E;
  localparam logic [31:0] ADDR_LSU_MCA_STATUS        = 32'h0000_040D;

  // Reset values
  localparam logic [63:0] CYCLE_COUNTER_RESET        = 64'h0000_0000_0000_0000;
  localparam logic [63:0] IRQ_CTRL_BASE_RESET        = 64'h0000_0000_FEE0_0000;
  localparam logic [63:0] CLUSTER_IDENT_RESET        = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MEMTYPE_RANGE_CAPS_RESET   = 64'h0000_0000_0000_0508;
  localparam logic [63:0] SYSCALL_CS_RESET           = 64'h0000_0000_0000_0000;
  localparam logic [63:0] SYSCALL_SP_RESET           = 64'h0000_0000_0000_0000;

  // Field positions
  localparam int          IRQ_BASE_ADDR_MSB          = 47;
  localparam int          IRQ_BASE_ADDR_LSB          = 12;
  localparam int          IRQ_ENABLE_BIT             = 11;
  localparam int          BOOT_CORE_BIT              = 8;
  localparam logic [63:0] IRQ_CTRL_BASE_WMASK        = 64'h0000_FFFF_FFFF_F900;
  localparam logic [63:0] SYSCALL_CS_WMASK           = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] SYSCALL_SP_WMASK           = 64'h0000_0000_FFFF_FFFF;
  localparam logic [15:0] GP_ERROR_CODE              = 16'h0000;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_ALIAS_WAIT
  } access_state_e;

endpackage : msr_pkg

// ### hw/rst_sync.sv
// Two-stage reset release synchroniser
`timescale 1ns/100ps
module rst_sync (
  // Clock and raw reset
  input  wire logic clock_i,
  input  wire logic rstn_i,
  // Released reset
  output logic      rstn_o
);

  logic meta_r;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= 1'b0;
      rstn_o <= 1'b0;
    end
    else
    begin
      meta_r <= 1'b1;
      rstn_o <= meta_r;
    end
  end

endmodule : rst_sync

// ### hw/cycle_counter_unit.sv
// Free-running 64-bit cycle counter with software load
`timescale 1ns/100ps
module cycle_counter_unit (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Software load
  input  wire logic        load_i,
  input  wire logic [63:0] load_value_i,
  // Count
  output logic      [63:0] count_o
);

  // No power-state input exists, so the rate never changes
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      count_o <= msr_pkg::CYCLE_COUNTER_RESET;
    else if (load_i)
      count_o <= load_value_i;
    else
      count_o <= count_o + 64'h0000_0000_0000_0001;
  end

endmodule : cycle_counter_unit

// ### verification/mca_model.sv
// Behavioural machine-check register pair behind the alias port
`timescale 1ns/100ps
module mca_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Answer delay in cycles
  input  wire logic [3:0]  delay_i,
  // Forwarded access
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic [63:0] req_wdata_i,
  // Answer
  output logic             rsp_valid_o,
  output logic      [63:0] rsp_rdata_o
);
  logic [63:0] addr_reg;
  logic [63:0] status_reg;
  logic [63:0] data;
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Arbitrary start values, storage has no defined reset
    addr_reg    = 64'h1111_2222_3333_4444;
    status_reg  = 64'h5555_6666_7777_8888;
    rsp_valid_o = 1'b0;
    rsp_rdata_o = 64'hA5A5_A5A5_A5A5_A5A5;
    forever
    begin
      @(posedge clock_i);
      if (rstn_i === 1'b1 && req_valid_i === 1'b1)
      begin
        data = 64'hDEAD_0000_DEAD_0000;
        if (req_write_i === 1'b1 && req_addr_i === 32'h0000_040E)
          addr_reg = req_wdata_i;
        if (req_write_i === 1'b1 && req_addr_i === 32'h0000_040D)
          status_reg = req_wdata_i;
        if (req_write_i === 1'b0 && req_addr_i === 32'h0000_040E)
          data = addr_reg;
        if (req_write_i === 1'b0 && req_addr_i === 32'h0000_040D)
          data = status_reg;
        repeat (delay_i) @(posedge clock_i);
        rsp_valid_o <= 1'b1;
        rsp_rdata_o <= data;
        @(posedge clock_i);
        // Stale data inverted so a late capture cannot pass
        rsp_valid_o <= 1'b0;
        rsp_rdata_o <= ~data;
      end
    end
  end
endmodule : mca_model

// ### verification/msr_bank_tb.sv
// Self-checking bench for the model-specific register bank
`timescale 1ns/100ps
module msr_bank_tb;
  logic        clock_i, rstn_i, boot_core_i, req_valid_i, req_write_i;
  logic [31:0] req_addr_i, mca_req_addr_o;
  logic [63:0] req_wdata_i, rsp_rdata_o, mca_req_wdata_o, mca_rsp_rdata_i;
  logic        req_ready_o, rsp_valid_o, rsp_gp_fault_o, mca_req_valid_o;
  logic        mca_req_write_o, mca_rsp_valid_i, irq_ctrl_reg_set_en_o;
  logic        irq_accept_vectored_o;
  logic [15:0] rsp_err_code_o, syscall_code_segment_o;
  logic [63:0] irq_ctrl_base_o, cycle_counter_o, rd, c0;
  logic [31:0] syscall_stack_pointer_o;
  logic [3:0]  mca_delay;
  logic        flt;
  logic [15:0] ec;
  int          miscompares, total_checks;
  ////////////////////////////////////////////////////////////////////////////////
  msr_bank dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .boot_core_i(boot_core_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .rsp_gp_fault_o(rsp_gp_fault_o),
    .rsp_err_code_o(rsp_err_code_o), .mca_req_valid_o(mca_req_valid_o),
    .mca_req_write_o(mca_req_write_o), .mca_req_addr_o(mca_req_addr_o),
    .mca_req_wdata_o(mca_req_wdata_o), .mca_rsp_valid_i(mca_rsp_valid_i),
    .mca_rsp_rdata_i(mca_rsp_rdata_i), .irq_ctrl_base_o(irq_ctrl_base_o),
    .irq_ctrl_reg_set_en_o(irq_ctrl_reg_set_en_o),
    .irq_accept_vectored_o(irq_accept_vectored_o), .cycle_counter_o(cycle_counter_o),
    .syscall_code_segment_o(syscall_code_segment_o),
    .syscall_stack_pointer_o(syscall_stack_pointer_o));
  mca_model mca_u (.clock_i(clock_i), .rstn_i(rstn_i), .delay_i(mca_delay),
    .req_valid_i(mca_req_valid_o), .req_write_i(mca_req_write_o),
    .req_addr_i(mca_req_addr_o), .req_wdata_i(mca_req_wdata_o),
    .rsp_valid_o(mca_rsp_valid_i), .rsp_rdata_o(mca_rsp_rdata_i));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_up_if(input logic hit);
    if (hit)
    begin
      miscompares++;
      summarize();
    end
  endtask : give_up_if
  // Request held until taken, answer caught at its single-cycle pulse
  task automatic access(input logic wr, input logic [31:0] addr, input logic [63:0] wd);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i  <= addr;
    req_wdata_i <= wd;
    do begin @(posedge clock_i); n++; end while (req_ready_o !== 1'b1 && n < 50);
    give_up_if(n >= 50);
    req_valid_i <= 1'b0;
    req_wdata_i <= ~wd;
    n = 0;
    do begin @(posedge clock_i); n++; end while (rsp_valid_o !== 1'b1 && n < 100);
    give_up_if(n >= 100);
    rd  = rsp_rdata_o;
    flt = rsp_gp_fault_o;
    ec  = rsp_err_code_o;
  endtask : access
  task automatic do_reset(input logic boot);
    int n;
    n = 0;
    boot_core_i <= boot;
    rstn_i      <= 1'b0;
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    do begin @(posedge clock_i); n++; end while (req_ready_o !== 1'b1 && n < 50);
    give_up_if(n >= 50);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values(input logic boot);
    logic [31:0] a [5] = '{32'h0000_00FE, 32'h0000_002A, 32'h0000_001B, 32'h0000_0174,
                           32'h0000_0175};
    logic [63:0] e [5] = '{64'h0000_0000_0000_0508, 64'h0, 64'h0000_0000_FEE0_0000, 64'h0,
                           64'h0};
    e[2][8] = boot;
    for (int i = 0; i < 5; i++)
    begin
      access(1'b0, a[i], 64'h0);
      check(rd, e[i]);
      check({63'h0, flt}, 64'h0);
    end
    check({62'h0, irq_ctrl_reg_set_en_o, irq_accept_vectored_o}, 64'h0);
    access(1'b0, 32'h0000_0010, 64'h0);
    c0 = rd;
    access(1'b0, 32'h0000_0010, 64'h0);
    check({63'h0, c0 < 64'h0000_0000_0000_0040}, 64'h1);
    check(rd - c0, 64'h2);
    $display("reset values finished");
  endtask : test_reset_values
  task automatic test_counter_load;
    logic [63:0] v [2] = '{64'h0000_0000_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF};
    for (int i = 0; i < 2; i++)
    begin
      access(1'b1, 32'h0000_0010, v[i]);
      access(1'b0, 32'h0000_0010, 64'h0);
      check(rd, v[i] + 64'h1);
      check(cycle_counter_o, v[i] + 64'h1);
    end
    $display("counter load finished");
  endtask : test_counter_load
  task automatic test_irq_base;
    logic [63:0] v [2] = '{64'h0000_ABCD_E000_0900, 64'h0000_0000_FEE0_0000};
    for (int i = 0; i < 2; i++)
    begin
      access(1'b1, 32'h0000_001B, v[i]);
      access(1'b0, 32'h0000_001B, 64'h0);
      check(rd, v[i]);
      check(irq_ctrl_base_o, v[i]);
      check({62'h0, irq_ctrl_reg_set_en_o, irq_accept_vectored_o}, {62'h0, {2{~i[0]}}});
    end
    $display("interrupt base finished");
  endtask : test_irq_base
  task automatic test_refusals;
    access(1'b1, 32'h0000_002A, 64'h0000_0000_0003_0000);
    check({47'h0, flt, ec}, {47'h1, 16'h0000});
    access(1'b0, 32'h0000_002A, 64'h0);
    check({63'h0, flt}, 64'h0);
    check(rd, 64'h0);
    access(1'b1, 32'h0000_00FE, 64'h0);
    check({63'h0, flt}, 64'h0);
    access(1'b0, 32'h0000_00FE, 64'h0);
    check(rd, 64'h0000_0000_0000_0508);
    access(1'b0, 32'h0000_0123, 64'h0);
    check({63'h0, flt}, 64'h1);
    $display("refusals finished");
  endtask : test_refusals
  task automatic test_syscall;
    access(1'b1, 32'h0000_0174, 64'hFFFF_FFFF_0000_BEEF);
    access(1'b0, 32'h0000_0174, 64'h0);
    check(rd, 64'h0000_0000_0000_BEEF);
    check({48'h0, syscall_code_segment_o}, 64'h0000_0000_0000_BEEF);
    access(1'b1, 32'h0000_0175, 64'h0000_0000_DEAD_BEEF);
    access(1'b0, 32'h0000_0175, 64'h0);
    check(rd, 64'h0000_0000_DEAD_BEEF);
    check({32'h0, syscall_stack_pointer_o}, 64'h0000_0000_DEAD_BEEF);
    $display("system call finished");
  endtask : test_syscall
  task automatic test_alias;
    mca_delay <= 4'h0;
    access(1'b1, 32'h0000_0000, 64'h0123_4567_89AB_CDEF);
    mca_delay <= 4'h6;
    access(1'b1, 32'h0000_0001, 64'hFEDC_BA98_7654_3210);
    access(1'b0, 32'h0000_0000, 64'h0);
    check(rd, 64'h0123_4567_89AB_CDEF);
    check({63'h0, flt}, 64'h0);
    mca_delay <= 4'h0;
    access(1'b0, 32'h0000_0001, 64'h0);
    check(rd, 64'hFEDC_BA98_7654_3210);
    $display("alias finished");
  endtask : test_alias
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    miscompares  = 0;
    total_checks = 0;
    rstn_i       = 1'b0;
    boot_core_i  = 1'b0;
    req_valid_i  = 1'b0;
    req_write_i  = 1'b0;
    req_addr_i   = 32'h0000_0000;
    req_wdata_i  = 64'h0;
    mca_delay    = 4'h0;
    do_reset(1'b0);
    test_reset_values(1'b0);
    test_counter_load();
    test_irq_base();
    test_refusals();
    test_syscall();
    test_alias();
    // Second reset in mid-run, now as boot core
    do_reset(1'b1);
    test_reset_values(1'b1);
    summarize();
  end
endmodule : msr_bank_tb
